// >>> inc/ctr_pkg.sv
package ctr_pkg;
	// counting modes of one counter resource
	typedef enum logic [2:0] {
		CntQuad1x,
		CntQuad2x,
		CntQuad4x,
		CntUp,
		CntDown,
		CntEdgeTimer,
		CntDualEdgeTimer,
		CntPulseCatch
	} count_mode_t;

	// discrete output reactions to an input event
	typedef enum logic [2:0] {
		OutSet,
		OutReset,
		OutPulseOn,
		OutPulseOff,
		OutToggle,
		OutResetCount,
		OutNone
	} out_action_t;

	// motion profile selection
	typedef enum logic [1:0] {
		ProfVelocity,
		ProfRunToLimit,
		ProfRunToPosition,
		ProfStored
	} profile_t;

	// module state shown on the health and fault lamps
	typedef enum logic [2:0] {
		ModRun,
		ModHwFail,
		ModBoot,
		ModProgram,
		ModSelfDiagFail,
		ModWatchdog
	} module_state_t;

	// role of one input point
	typedef enum logic [1:0] {
		RoleCount,
		RoleReset,
		RoleInhibit,
		RoleCapture
	} input_role_t;

	// stored configuration of one counter resource
	typedef struct packed {
		count_mode_t mode;
		logic [1:0]  phaseA;
		logic [1:0]  phaseB;
		logic [1:0]  resetPin;
		logic [1:0]  inhibitPin;
		logic [1:0]  capturePin;
		logic        resetEn;
		logic        inhibitEn;
		logic        captureEn;
	} counter_cfg_t;

	// stored configuration of one discrete output
	typedef struct packed {
		logic        rawMode;
		logic        rawValue;
		logic        source;
		out_action_t action;
		logic [31:0] setpoint;
		logic        usePulse;
	} output_cfg_t;

	// pulse channel command
	typedef struct packed {
		logic        enable;
		logic        stepDirMode;
		profile_t    profile;
		logic        direction;
		logic [31:0] periodUs;
		logic [6:0]  dutyPercent;
		logic [31:0] target;
		logic        limitHit;
	} pulse_cmd_t;

	localparam int          ClockHz        = 20_000_000;
	localparam int          MicroTickNs    = 1000;
	localparam int          ClockNs        = 1_000_000_000 / ClockHz;
	localparam int          MicroTickCount = (MicroTickNs + ClockNs - 1) / ClockNs;
	localparam int          MinPeriodUs    = 4;
	localparam int          MaxPeriodUs    = 50_000;
	localparam logic [6:0]  DutyMin        = 7'h01;
	localparam logic [6:0]  DutyMax        = 7'h63;
	localparam logic [6:0]  DutyDefault    = 7'h32;
	localparam logic [6:0]  DutyFull       = 7'h64;
	localparam int          BlinkMs        = 250;
	localparam int          BlinkCount     = BlinkMs * (ClockHz / 1000);
	localparam int          OutPulseUs     = 1000;
	localparam logic [31:0] Zero32         = 32'h0000_0000;
	localparam logic [31:0] One32          = 32'h0000_0001;
	localparam logic [31:0] SignMask       = 32'h8000_0000;
endpackage

// >>> testbench/counter_timer_unit_checker.sv
`timescale 1ns/1ps
module counter_timer_unit_checker (
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire logic [3:0]             fieldInput,
	input wire ctr_pkg::counter_cfg_t  counterCfg0,
	input wire ctr_pkg::output_cfg_t   outputCfg0,
	input wire logic                   pulseChannelEn,
	input wire ctr_pkg::module_state_t moduleState,
	input wire logic [31:0]            count0,
	input wire logic                   discrete_output_zero,
	input wire logic                   discrete_output_one,
	input wire logic                   healthLamp,
	input wire logic                   user_program_fault_lamp,
	input wire logic [1:0]             outputLamp
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// lamps are registered, so the state must be seen on two edges
	sequence held(ctr_pkg::module_state_t s);
		rst_n && moduleState == s ##1 moduleState == s;
	endsequence
	// quiet inputs: no edge still in the sync and decode pipe
	sequence quiet;
		($stable(fieldInput) && $stable(counterCfg0) && $stable(outputCfg0)) [*8];
	endsequence
	a_run_lamps: assert property (held(ctr_pkg::ModRun) |-> healthLamp && !user_program_fault_lamp)
		else $error("run lamps wrong");
	a_fail_lamps: assert property (held(ctr_pkg::ModHwFail) |-> healthLamp && user_program_fault_lamp)
		else $error("hardware fail lamps wrong");
	a_prog_fault_off: assert property (held(ctr_pkg::ModProgram) |-> !user_program_fault_lamp)
		else $error("program mode fault lamp lit");
	a_diag_health_off: assert property (held(ctr_pkg::ModSelfDiagFail) |-> !healthLamp)
		else $error("self test health lamp lit");
	a_wdog_lamps: assert property (held(ctr_pkg::ModWatchdog) |-> !healthLamp && user_program_fault_lamp)
		else $error("watchdog lamps wrong");
	a_lamp_follows: assert property (1'b1 |-> outputLamp == $past({discrete_output_one, discrete_output_zero}))
		else $error("output lamp not following output");
	a_raw_drive: assert property ((outputCfg0.rawMode && !pulseChannelEn) [*2]
		|-> discrete_output_zero == $past(outputCfg0.rawValue))
		else $error("raw value not on output zero");
	a_count_still: assert property (quiet |-> $stable(count0))
		else $error("count moved without an input edge");
endmodule
bind counter_timer_unit counter_timer_unit_checker chk_u (.clock(clock), .rst_n(rst_n), .fieldInput(fieldInput),
	.counterCfg0(counterCfg0), .outputCfg0(outputCfg0), .pulseChannelEn(pulseChannelEn), .moduleState(moduleState),
	.count0(count0), .discrete_output_zero(discrete_output_zero), .discrete_output_one(discrete_output_one),
	.healthLamp(healthLamp), .user_program_fault_lamp(user_program_fault_lamp), .outputLamp(outputLamp));

// >>> testbench/counter_timer_unit_tb.sv
`timescale 1ns/1ps
module counter_timer_unit_tb;
	typedef struct {
		int          kind;
		logic [31:0] value;
		string       name;
	} note_t;
	logic                   clock;
	logic                   rst_n;
	logic [3:0]             fieldInput;
	ctr_pkg::counter_cfg_t  cfg0;
	ctr_pkg::counter_cfg_t  cfg1;
	ctr_pkg::output_cfg_t   ocfg0;
	ctr_pkg::output_cfg_t   ocfg1;
	ctr_pkg::module_state_t state;
	ctr_pkg::pulse_cmd_t    pulseCmd;
	ctr_pkg::count_mode_t   modes [5];
	ctr_pkg::out_action_t   acts [4];
	logic [31:0]            count0;
	logic [31:0]            capture0;
	logic [31:0]            interval0;
	logic                   discrete_output_zero;
	logic                   discrete_output_one;
	logic                   healthLamp;
	logic                   user_program_fault_lamp;
	logic [1:0]             outputLamp;
	logic [1:0]             outExp;
	logic                   pulseEn;
	logic [31:0]            pulsePos;
	logic [31:0]            k;
	note_t                  notes [$];
	event                   checkNow;
	int                     errors;
	int                     samplesChecked;
	int                     seed;
	int                     n;
	field_model field_u (.clock(clock), .fieldInput(fieldInput));
	counter_timer_unit #(.BlinkCycles(8)) dut_u (.clock(clock), .rst_n(rst_n), .fieldInput(fieldInput),
		.counterCfg0(cfg0), .counterCfg1(cfg1), .outputCfg0(ocfg0), .outputCfg1(ocfg1),
		.pulseChannelEn(pulseEn), .pulseCmd(pulseCmd), .moduleState(state), .count0(count0), .count1(),
		.capture0(capture0), .capture1(), .interval0(interval0), .interval1(), .pulseCaught(),
		.pulsePosition(pulsePos), .pulseRunning(), .discrete_output_zero(discrete_output_zero),
		.discrete_output_one(discrete_output_one), .healthLamp(healthLamp),
		.user_program_fault_lamp(user_program_fault_lamp), .first_input_function(),
		.second_input_function(), .outputLamp(outputLamp));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic finish_test();
		$display("checked %0d, mismatches %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// notes are taken on the falling edge, where outputs have settled
	task automatic note(int kind, logic [31:0] v, string nm);
		@(negedge clock);
		notes.push_back('{kind, v, nm});
		->checkNow;
	endtask
	task automatic compare_word(string nm, logic [31:0] e, logic [31:0] o, int tol);
		samplesChecked++;
		if (!(o === e || (tol > 0 && !$isunknown(o) && (o - e + tol) <= 2 * tol))) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, o);
		end
	endtask
	task automatic compare_bits(string nm, logic [1:0] e, logic [1:0] o);
		samplesChecked++;
		if (o !== e) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, o);
		end
	endtask
	// interval allows one tick of sampling jitter
	always begin
		note_t m;
		@(checkNow);
		while (notes.size() > 0) begin
			m = notes.pop_front();
			case (m.kind)
				0: compare_word(m.name, m.value, count0, 0);
				1: compare_word(m.name, m.value, capture0, 0);
				2: compare_word(m.name, m.value, interval0, 1);
				3: compare_bits(m.name, m.value[1:0], {discrete_output_one, discrete_output_zero});
				4: compare_bits(m.name, m.value[1:0], outputLamp);
				6: compare_word(m.name, m.value, pulsePos, 0);
				default: compare_bits(m.name, m.value[1:0], {healthLamp, user_program_fault_lamp});
			endcase
		end
	end
	initial begin
		repeat (30000) @(posedge clock);
		errors++;
		finish_test();
	end
	task automatic clear_count();
		field_u.pulse(3, 6, 6);
		note(0, 32'h0, "count cleared");
	endtask
	initial begin
		seed = 32'hddafc088;
		modes = '{ctr_pkg::CntQuad1x, ctr_pkg::CntQuad2x, ctr_pkg::CntQuad4x, ctr_pkg::CntUp, ctr_pkg::CntDown};
		acts = '{ctr_pkg::OutSet, ctr_pkg::OutReset, ctr_pkg::OutToggle, ctr_pkg::OutPulseOn};
		rst_n = 1'b0;
		cfg0 = '{mode: ctr_pkg::CntQuad4x, phaseA: 2'h0, phaseB: 2'h1, resetPin: 2'h3, inhibitPin: 2'h2,
			capturePin: 2'h2, resetEn: 1'b1, inhibitEn: 1'b0, captureEn: 1'b0};
		cfg1 = cfg0;
		ocfg0 = '{rawMode: 1'b1, rawValue: 1'b0, source: 1'b0, action: ctr_pkg::OutNone,
			setpoint: 32'h0, usePulse: 1'b0};
		ocfg1 = ocfg0;
		pulseCmd = '0;
		pulseEn = 1'b0;
		state = ctr_pkg::ModRun;
		repeat (14) @(posedge clock);
		note(0, 32'h0, "count in reset");
		note(5, 32'h0, "lamps in reset");
		@(posedge clock);
		rst_n <= 1'b1;
		// quadrature, up and down counting modes; quad counts up then below zero
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			cfg0.mode <= modes[i];
			clear_count();
			n = 1 + ($unsigned($random(seed)) % 4);
			k = 32'h1 << (i < 3 ? i : 0);
			if (i < 3) begin
				field_u.quad(1'b0, 4 * n);
				note(0, n * k, "quad count up");
				field_u.quad(1'b1, 4 * (n + 1));
				note(0, 32'h0 - k, "quad count down");
			end else begin
				repeat (n) field_u.pulse(0, 6, 6);
				note(0, i == 3 ? n : 32'h0 - n, "plain count");
			end
		end
		$display("test count modes done");
		// inhibit blocks counting, capture latches it
		@(posedge clock);
		cfg0.mode <= ctr_pkg::CntQuad4x;
		cfg0.inhibitEn <= 1'b1;
		clear_count();
		field_u.level(2, 1'b1);
		field_u.quad(1'b0, 8);
		note(0, 32'h0, "inhibited count");
		field_u.level(2, 1'b0);
		field_u.quad(1'b0, 8);
		note(0, 32'h8, "count after inhibit");
		@(posedge clock);
		cfg0.inhibitEn <= 1'b0;
		cfg0.captureEn <= 1'b1;
		field_u.pulse(2, 6, 6);
		note(1, 32'h8, "captured count");
		$display("test inhibit and capture done");
		// 201 cycles rise to rise is about 10 us, 100 cycles high is 5 us
		@(posedge clock);
		cfg0.mode <= ctr_pkg::CntEdgeTimer;
		repeat (3) field_u.pulse(0, 100, 100);
		note(2, 32'd10, "edge interval");
		@(posedge clock);
		cfg0.mode <= ctr_pkg::CntDualEdgeTimer;
		repeat (2) field_u.pulse(0, 100, 100);
		note(2, 32'd5, "dual edge interval");
		$display("test timers done");
		// output zero reacts to the count reaching its setpoint
		@(posedge clock);
		cfg0.mode <= ctr_pkg::CntUp;
		ocfg0.rawMode <= 1'b0;
		ocfg0.setpoint <= 1 + ($unsigned($random(seed)) % 6);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			ocfg0.action <= acts[i];
			clear_count();
			repeat (ocfg0.setpoint) field_u.pulse(0, 6, 6);
			outExp = {1'b0, i != 1};
			note(3, outExp, "event output");
			note(4, outExp, "event output lamp");
		end
		$display("test event outputs done");
		// program drives output one directly
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			ocfg1.rawValue <= $random(seed);
			@(posedge clock);
			outExp[1] = ocfg1.rawValue;
			note(3, outExp, "raw outputs");
			note(4, outExp, "raw output lamps");
		end
		$display("test raw outputs done");
		// pulse channel runs down to a target below zero at the fastest rate, then idles
		@(posedge clock);
		pulseCmd <= '{enable: 1'b1, stepDirMode: 1'b1, profile: ctr_pkg::ProfRunToPosition, direction: 1'b1,
			periodUs: 32'h4, dutyPercent: ctr_pkg::DutyDefault, target: 32'hffff_fffd, limitHit: 1'b0};
		pulseEn <= 1'b1;
		repeat (400) @(posedge clock);
		note(6, 32'hffff_fffd, "pulse position");
		note(3, 32'h2, "step and direction idle");
		$display("test pulse channel done");
		// steady lamp pairs
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			state <= i == 0 ? ctr_pkg::ModHwFail : i == 1 ? ctr_pkg::ModWatchdog : ctr_pkg::ModRun;
			repeat (2) @(posedge clock);
			note(5, i == 0 ? 32'h3 : i == 1 ? 32'h1 : 32'h2, "lamp pair");
		end
		@(posedge clock);
		state <= ctr_pkg::ModProgram;
		repeat (4) @(posedge clock);
		state <= ctr_pkg::ModSelfDiagFail;
		repeat (4) @(posedge clock);
		$display("test lamps done");
		finish_test();
	end
endmodule

// >>> testbench/field_model.sv
`timescale 1ns/1ps
// encoder and sensor stand-in on field points a..d
module field_model (
	input  wire logic       clock,
	output logic      [3:0] fieldInput
);
	logic [1:0] upSeq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
	initial fieldInput = 4'h0;
	task automatic gap(input int c);
		repeat (c) @(posedge clock);
	endtask
	// a leads b going up, b leads a going down; six cycles per edge
	task automatic quad(input logic down, input int steps);
		logic [1:0] ph;
		for (int i = 0; i < steps; i++) begin
			ph = upSeq[i % 4];
			@(posedge clock);
			fieldInput[1:0] <= down ? {ph[0], ph[1]} : ph;
			gap(5);
		end
		gap(2);
	endtask
	// widths in cycles; never under the minimum edge spacing
	task automatic pulse(input int pin, input int hi, input int lo);
		@(posedge clock);
		fieldInput[pin] <= 1'b1;
		gap(hi);
		fieldInput[pin] <= 1'b0;
		gap(lo);
	endtask
	task automatic level(input int pin, input logic v);
		@(posedge clock);
		fieldInput[pin] <= v;
		gap(6);
	endtask
endmodule

// >>> verilog/counter_timer_unit.sv
`timescale 1ns/1ps
module counter_timer_unit #(
	parameter int BlinkCycles = ctr_pkg::BlinkCount
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic [3:0]              fieldInput,
	input  wire ctr_pkg::counter_cfg_t   counterCfg0,
	input  wire ctr_pkg::counter_cfg_t   counterCfg1,
	input  wire ctr_pkg::output_cfg_t    outputCfg0,
	input  wire ctr_pkg::output_cfg_t    outputCfg1,
	input  wire logic                    pulseChannelEn,
	input  wire ctr_pkg::pulse_cmd_t     pulseCmd,
	input  wire ctr_pkg::module_state_t  moduleState,
	output logic [31:0]                  count0,
	output logic [31:0]                  count1,
	output logic [31:0]                  capture0,
	output logic [31:0]                  capture1,
	output logic [31:0]                  interval0,
	output logic [31:0]                  interval1,
	output logic [1:0]                   pulseCaught,
	output logic [31:0]                  pulsePosition,
	output logic                         pulseRunning,
	output logic                         discrete_output_zero,
	output logic                         discrete_output_one,
	output logic                         healthLamp,
	output logic                         user_program_fault_lamp,
	output logic                         first_input_function,
	output logic                         second_input_function,
	output logic [1:0]                   outputLamp
);
	typedef struct packed {
		logic [3:0]  syncA;
		logic [3:0]  syncB;
		logic [3:0]  lastIn;
		logic [7:0]  microDiv;
		logic [31:0] blinkDiv;
		logic        blink;
		logic [1:0][31:0] count;
		logic [1:0][31:0] capture;
		logic [1:0][31:0] timer;
		logic [1:0][31:0] interval;
		logic [1:0]  timing;
		logic [1:0]  caught;
		logic [1:0]  active;
		logic [1:0][31:0] activeHold;
		logic [1:0]  outLevel;
		logic [1:0][31:0] outPulse;
		logic [1:0]  lastMatch;
		logic        out0;
		logic        out1;
		logic        health;
		logic        fault;
		logic        fn1;
		logic        fn2;
		logic [1:0]  lamp;
	} unit_state_t;

	unit_state_t state;
	unit_state_t next_state;
	logic        microTick;
	logic [1:0]  qUp;
	logic [1:0]  qDown;
	logic        stepA;
	logic        stepB;
	logic        pgRunning;
	logic [31:0] pgPos;
	ctr_pkg::counter_cfg_t cfg [2];
	ctr_pkg::output_cfg_t  ocfg [2];

	assign cfg[0] = counterCfg0;
	assign cfg[1] = counterCfg1;
	assign ocfg[0] = outputCfg0;
	assign ocfg[1] = outputCfg1;
	assign microTick = (state.microDiv == 8'(ctr_pkg::MicroTickCount - 1));

	// phase decoders, routed from the configured input points
	quad_decoder dec0 (
		.clock     (clock),
		.rst_n     (rst_n),
		.mode      (counterCfg0.mode),
		.phaseA    (state.syncB[counterCfg0.phaseA]),
		.phaseB    (state.syncB[counterCfg0.phaseB]),
		.countUp   (qUp[0]),
		.countDown (qDown[0])
	);
	quad_decoder dec1 (
		.clock     (clock),
		.rst_n     (rst_n),
		.mode      (counterCfg1.mode),
		.phaseA    (state.syncB[counterCfg1.phaseA]),
		.phaseB    (state.syncB[counterCfg1.phaseB]),
		.countUp   (qUp[1]),
		.countDown (qDown[1])
	);

	pulse_gen pgen (
		.clock     (clock),
		.rst_n     (rst_n),
		.microTick (microTick),
		.cmd       (pulseCmd),
		.stepA     (stepA),
		.stepB     (stepB),
		.running   (pgRunning),
		.position  (pgPos)
	);

	// rising edge of a synchronised input point
	function automatic logic riseOf(input logic [3:0] now, input logic [3:0] last, input logic [1:0] pin);
		return now[pin] && !last[pin];
	endfunction

	// lamp pair for a module state
	function automatic logic [1:0] lampsFor(input ctr_pkg::module_state_t s, input logic b);
		case (s)
			ctr_pkg::ModRun:          return {1'b1, 1'b0};
			ctr_pkg::ModHwFail:       return {1'b1, 1'b1};
			ctr_pkg::ModBoot:         return {b, b};
			ctr_pkg::ModProgram:      return {b, 1'b0};
			ctr_pkg::ModSelfDiagFail: return {1'b0, b};
			ctr_pkg::ModWatchdog:     return {1'b0, 1'b1};
			default:                  return {1'b0, 1'b0};
		endcase
	endfunction

	always_comb begin
		logic [1:0]  rawLamp;
		logic        rstEv;
		logic        capEv;
		logic        inhibit;
		logic        risePhase;
		logic        fallPhase;
		logic        match;
		logic        ev;
		logic        lvl;
		rawLamp = '0;
		rstEv = 1'b0;
		capEv = 1'b0;
		inhibit = 1'b0;
		risePhase = 1'b0;
		fallPhase = 1'b0;
		match = 1'b0;
		ev = 1'b0;
		lvl = 1'b0;
		next_state = state;
		// two-stage synchroniser; only syncB is read by logic
		next_state.syncA = fieldInput;
		next_state.syncB = state.syncA;
		next_state.lastIn = state.syncB;
		next_state.microDiv = microTick ? 8'h00 : state.microDiv + 8'h01;
		if (state.blinkDiv >= 32'(BlinkCycles - 1)) begin
			next_state.blinkDiv = ctr_pkg::Zero32;
			next_state.blink = !state.blink;
		end else begin
			next_state.blinkDiv = state.blinkDiv + ctr_pkg::One32;
		end
		for (int i = 0; i < 2; i++) begin
			rstEv = cfg[i].resetEn && riseOf(state.syncB, state.lastIn, cfg[i].resetPin);
			capEv = cfg[i].captureEn && riseOf(state.syncB, state.lastIn, cfg[i].capturePin);
			inhibit = cfg[i].inhibitEn && state.syncB[cfg[i].inhibitPin];
			risePhase = riseOf(state.syncB, state.lastIn, cfg[i].phaseA);
			fallPhase = !state.syncB[cfg[i].phaseA] && state.lastIn[cfg[i].phaseA];
			// capture sees the value before any same-cycle clear
			if (capEv) begin
				next_state.capture[i] = state.count[i];
			end
			if (rstEv) begin
				next_state.count[i] = ctr_pkg::Zero32;
			end else if (!inhibit && qUp[i]) begin
				next_state.count[i] = state.count[i] + ctr_pkg::One32;
			end else if (!inhibit && qDown[i]) begin
				next_state.count[i] = state.count[i] - ctr_pkg::One32;
			end
			// timers: edge measures rise to rise, dual edge rise to fall
			if (cfg[i].mode == ctr_pkg::CntEdgeTimer || cfg[i].mode == ctr_pkg::CntDualEdgeTimer) begin
				if (state.timing[i] && microTick) begin
					next_state.timer[i] = state.timer[i] + ctr_pkg::One32;
				end
				if (risePhase) begin
					if (cfg[i].mode == ctr_pkg::CntEdgeTimer && state.timing[i]) begin
						next_state.interval[i] = state.timer[i];
					end
					next_state.timer[i] = ctr_pkg::Zero32;
					next_state.timing[i] = 1'b1;
				end else if (fallPhase && cfg[i].mode == ctr_pkg::CntDualEdgeTimer && state.timing[i]) begin
					next_state.interval[i] = state.timer[i];
					next_state.timing[i] = 1'b0;
				end
			end else begin
				next_state.timing[i] = 1'b0;
			end
			// caught pulse is sticky; a catch beside a clear wins so no pulse is lost
			next_state.caught[i] = (cfg[i].mode == ctr_pkg::CntPulseCatch)
				&& (risePhase || (state.caught[i] && !rstEv));
			// activity window keeps the function lamp blinking briefly
			if (qUp[i] || qDown[i] || risePhase) begin
				next_state.activeHold[i] = 32'(BlinkCycles);
			end else if (state.activeHold[i] != ctr_pkg::Zero32) begin
				next_state.activeHold[i] = state.activeHold[i] - ctr_pkg::One32;
			end
			next_state.active[i] = state.timing[i] || (state.activeHold[i] != ctr_pkg::Zero32);
		end
		// discrete outputs respond to a setpoint match on their source counter
		for (int j = 0; j < 2; j++) begin
			match = (state.count[ocfg[j].source] == ocfg[j].setpoint);
			ev = match && !state.lastMatch[j];
			next_state.lastMatch[j] = match;
			lvl = state.outLevel[j];
			if (state.outPulse[j] != ctr_pkg::Zero32 && microTick) begin
				next_state.outPulse[j] = state.outPulse[j] - ctr_pkg::One32;
				if (state.outPulse[j] == ctr_pkg::One32) begin
					lvl = !lvl;
				end
			end
			if (ev) begin
				case (ocfg[j].action)
					ctr_pkg::OutSet:        lvl = 1'b1;
					ctr_pkg::OutReset:      lvl = 1'b0;
					ctr_pkg::OutToggle:     lvl = !lvl;
					ctr_pkg::OutPulseOn: begin
						lvl = 1'b1;
						next_state.outPulse[j] = 32'(ctr_pkg::OutPulseUs);
					end
					ctr_pkg::OutPulseOff: begin
						lvl = 1'b0;
						next_state.outPulse[j] = 32'(ctr_pkg::OutPulseUs);
					end
					ctr_pkg::OutResetCount: next_state.count[ocfg[j].source] = ctr_pkg::Zero32;
					default: begin
					end
				endcase
			end
			next_state.outLevel[j] = lvl;
		end
		// pulse channel takes both points when enabled, else discrete or raw
		if (pulseChannelEn) begin
			next_state.out0 = stepA;
			next_state.out1 = stepB;
		end else begin
			next_state.out0 = ocfg[0].rawMode ? ocfg[0].rawValue : next_state.outLevel[0];
			next_state.out1 = ocfg[1].rawMode ? ocfg[1].rawValue : next_state.outLevel[1];
		end
		rawLamp = lampsFor(moduleState, state.blink);
		next_state.health = rawLamp[1];
		next_state.fault = rawLamp[0];
		next_state.fn1 = state.active[0] && state.blink;
		next_state.fn2 = state.active[1] && state.blink;
		next_state.lamp = {state.out1, state.out0};
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// pulse outputs re-registered from pulse_gen; every other output taken straight from the state register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pulsePosition <= ctr_pkg::Zero32;
			pulseRunning <= 1'b0;
		end else begin
			pulsePosition <= pgPos;
			pulseRunning <= pgRunning;
		end
	end

	assign count0 = state.count[0];
	assign count1 = state.count[1];
	assign capture0 = state.capture[0];
	assign capture1 = state.capture[1];
	assign interval0 = state.interval[0];
	assign interval1 = state.interval[1];
	assign pulseCaught = state.caught;
	assign discrete_output_zero = state.out0;
	assign discrete_output_one = state.out1;
	assign healthLamp = state.health;
	assign user_program_fault_lamp = state.fault;
	assign first_input_function = state.fn1;
	assign second_input_function = state.fn2;
	assign outputLamp = state.lamp;
endmodule

// >>> verilog/pulse_gen.sv
`timescale 1ns/1ps
module pulse_gen (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                microTick,
	input  wire ctr_pkg::pulse_cmd_t cmd,
	output logic                     stepA,
	output logic                     stepB,
	output logic                     running,
	output logic [31:0]              position
);
	typedef struct packed {
		logic [31:0] phase;
		logic [31:0] pos;
		logic        level;
		logic        run;
		logic        a;
		logic        b;
	} pulse_state_t;

	pulse_state_t state;
	pulse_state_t next_state;

	// clamp period into the 20 Hz to 250 kHz band
	function automatic logic [31:0] clampPeriod(input logic [31:0] p);
		if (p < 32'(ctr_pkg::MinPeriodUs)) begin
			return 32'(ctr_pkg::MinPeriodUs);
		end else if (p > 32'(ctr_pkg::MaxPeriodUs)) begin
			return 32'(ctr_pkg::MaxPeriodUs);
		end
		return p;
	endfunction

	// out-of-range duty falls back to the default
	function automatic logic [6:0] clampDuty(input logic [6:0] d);
		if (d < ctr_pkg::DutyMin || d > ctr_pkg::DutyMax) begin
			return ctr_pkg::DutyDefault;
		end
		return d;
	endfunction

	always_comb begin
		logic [31:0] period;
		logic [38:0] highTime;
		logic        stop;
		period = clampPeriod(cmd.periodUs);
		highTime = 39'(period) * 39'(clampDuty(cmd.dutyPercent)) / 39'(ctr_pkg::DutyFull);
		// run-to-limit and run-to-position modes stop on limit or on reaching target
		stop = !cmd.enable;
		case (cmd.profile)
			ctr_pkg::ProfRunToLimit: stop = stop || cmd.limitHit;
			ctr_pkg::ProfRunToPosition: stop = stop || (state.pos == cmd.target);
			default: begin
			end
		endcase
		next_state = state;
		next_state.run = !stop;
		if (stop) begin
			next_state.phase = ctr_pkg::Zero32;
			next_state.level = 1'b0;
		end else if (microTick) begin
			if (state.phase + ctr_pkg::One32 >= period) begin
				next_state.phase = ctr_pkg::Zero32;
				next_state.pos = cmd.direction ? state.pos - ctr_pkg::One32 : state.pos + ctr_pkg::One32;
			end else begin
				next_state.phase = state.phase + ctr_pkg::One32;
			end
			next_state.level = 39'(next_state.phase) < highTime;
		end
		// step/direction or cw/ccw steering
		if (cmd.stepDirMode) begin
			next_state.a = next_state.level;
			next_state.b = cmd.direction;
		end else begin
			next_state.a = next_state.level && !cmd.direction;
			next_state.b = next_state.level && cmd.direction;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign stepA = state.a;
	assign stepB = state.b;
	assign running = state.run;
	assign position = state.pos;
endmodule

// >>> verilog/quad_decoder.sv
`timescale 1ns/1ps
module quad_decoder (
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire ctr_pkg::count_mode_t mode,
	input  wire logic               phaseA,
	input  wire logic               phaseB,
	output logic                    countUp,
	output logic                    countDown
);
	typedef struct packed {
		logic lastA;
		logic lastB;
		logic up;
		logic down;
	} quad_state_t;

	quad_state_t state;
	quad_state_t next_state;

	// edge resolution by mode; direction from which phase leads
	always_comb begin
		logic edgeA;
		logic edgeB;
		logic rise;
		edgeA = phaseA ^ state.lastA;
		edgeB = phaseB ^ state.lastB;
		rise = edgeA && phaseA;
		next_state = state;
		next_state.lastA = phaseA;
		next_state.lastB = phaseB;
		next_state.up = 1'b0;
		next_state.down = 1'b0;
		case (mode)
			ctr_pkg::CntQuad1x: begin
				// a rising while b low means a leads
				if (rise) begin
					next_state.up = !phaseB;
					next_state.down = phaseB;
				end
			end
			ctr_pkg::CntQuad2x: begin
				if (edgeA) begin
					next_state.up = phaseA ^ phaseB;
					next_state.down = !(phaseA ^ phaseB);
				end
			end
			ctr_pkg::CntQuad4x: begin
				if (edgeA && !edgeB) begin
					next_state.up = phaseA ^ phaseB;
					next_state.down = !(phaseA ^ phaseB);
				end else if (edgeB && !edgeA) begin
					next_state.up = !(phaseA ^ phaseB);
					next_state.down = phaseA ^ phaseB;
				end
			end
			ctr_pkg::CntUp: begin
				next_state.up = rise;
			end
			ctr_pkg::CntDown: begin
				next_state.down = rise;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign countUp = state.up;
	assign countDown = state.down;
endmodule
